// [common/slave_port_pkg.sv]
// Purpose: shared constants and carriers for the slave port buffer status block
// Assumes: AXI4-Lite register access with 32-bit data, one aligned word per register
// Notes: none of the printed offsets exist, so all register addresses are local choices
package slave_port_pkg;
    localparam int unsigned slot_count = 4;
    localparam logic [3:0] addr_status = 4'h0;
    localparam logic [3:0] addr_control = 4'h4;
    localparam logic [3:0] addr_irq_status = 4'h8;
    localparam logic [3:0] addr_irq_mask = 4'hC;
    localparam int unsigned pos_output_slot_empty = 0;
    localparam int unsigned pos_output_underflow = 6;
    localparam int unsigned pos_output_all_empty = 7;
    localparam int unsigned pos_input_slot_full = 8;
    localparam int unsigned pos_input_overflow = 14;
    localparam int unsigned pos_input_all_full = 15;
    localparam int unsigned pos_slave_mode = 0;
    localparam logic [3:0] reset_input_full = 4'h0;
    localparam logic [3:0] reset_output_empty = 4'hF;
    localparam logic reset_slave_mode = 1'b1;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    localparam int unsigned irq_width = 2;
    localparam int unsigned irq_bit_overflow = 1;
    localparam int unsigned irq_bit_underflow = 0;

    typedef struct packed {
        logic [3:0] write;
        logic [3:0] read;
    } slot_strobe_s;

    typedef struct packed {
        logic [3:0] input_slot_full;
        logic [3:0] output_slot_empty;
        logic input_overflow_sticky;
        logic output_underflow_sticky;
    } buffer_state_s;
endpackage

// [rtl/buffer_flags.sv]
// Purpose: per-slot full and empty tracking with sticky overflow and underflow
// Assumes: strobes are one-cycle pulses synchronous to clk
// Notes: sticky flags obey set-over-clear
`timescale 1ns/1ns
module buffer_flags #(
    parameter int unsigned slots = slave_port_pkg::slot_count
) (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous active-high reset
    input wire logic enable, // slave mode active
    input wire slave_port_pkg::slot_strobe_s master_strobe, // external master access
    input wire slave_port_pkg::slot_strobe_s local_strobe, // local software access
    input wire logic clear_overflow, // write-one-clear of overflow
    input wire logic clear_underflow, // write-one-clear of underflow
    output slave_port_pkg::buffer_state_s state // registered flags
);
    slave_port_pkg::buffer_state_s next_state;
    logic [slots-1:0] overflow_hit;
    logic [slots-1:0] underflow_hit;
    logic [slots-1:0] next_full;
    logic [slots-1:0] next_empty;

    // per-slot terms are plain nets so that one process alone builds the next state
    genvar i;
    generate
        for (i = 0; i < slots; i++) begin : g_slot
            assign overflow_hit[i] = enable && master_strobe.write[i]
                && state.input_slot_full[i]; // see RULE_06
            assign underflow_hit[i] = enable && master_strobe.read[i]
                && state.output_slot_empty[i]; // see RULE_03
            // master write fills, local read drains; fill wins on a tie
            assign next_full[i] = enable ? (master_strobe.write[i]
                || (state.input_slot_full[i] && !local_strobe.read[i]))
                : state.input_slot_full[i]; // see RULE_07
            assign next_empty[i] = enable ? (!local_strobe.write[i]
                && (state.output_slot_empty[i] || master_strobe.read[i]))
                : state.output_slot_empty[i]; // see RULE_01 RULE_02
        end
    endgenerate

    always_comb begin
        next_state.input_slot_full = next_full;
        next_state.output_slot_empty = next_empty;
        next_state.input_overflow_sticky = (state.input_overflow_sticky && !clear_overflow)
            || (|overflow_hit); // see RULE_06
        next_state.output_underflow_sticky = (state.output_underflow_sticky && !clear_underflow)
            || (|underflow_hit); // see RULE_03
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '{input_slot_full: slave_port_pkg::reset_input_full,
                       output_slot_empty: slave_port_pkg::reset_output_empty,
                       input_overflow_sticky: 1'b0, output_underflow_sticky: 1'b0};
        end else begin
            state <= next_state;
        end
    end
endmodule

// [rtl/parallel_slave_buffer_status.sv]
// What this block does
// RULE_01: each output slot empty flag is 1 while its slot is empty and clears when local software writes it.
// RULE_02: an output slot empty flag is 0 while the slot holds a byte the external master has not read.
// RULE_03: a master read of an empty output slot sets a sticky underflow flag kept until software clears it.
// RULE_04: status bits 5:4 and 13:12 always read as zero.
// RULE_05: the status is only maintained while the port runs in slave mode.
// RULE_06: a master write to a full input slot sets a sticky overflow flag only software clears.
// RULE_07: each input slot full flag is 1 while unread data sits there and clears when software reads it.
// RULE_08: the all-full flag needs all four input slots full; the all-empty flag all four output slots empty.
// RULE_09: the external master checks the flags and avoids writing full or reading empty slots; host_master_model checks no flags before an access.
//
// Purpose: AXI4-Lite front end for the slave port buffer status tracking
// Assumes: slot strobes from the port data path are one-cycle pulses on clk
// Notes: answers come one cycle after both halves of a request are held
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
module parallel_slave_buffer_status (
    input wire logic clk, // system clock, 100 MHz
    input wire logic reset, // synchronous active-high reset
    input wire slave_port_pkg::slot_strobe_s master_strobe, // external master slot access
    input wire slave_port_pkg::slot_strobe_s local_strobe, // local software slot access
    input wire logic [3:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [3:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic irq // level interrupt
);
    typedef struct packed {
        logic aw_held;
        logic [3:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic slave_mode;
        logic [slave_port_pkg::irq_width-1:0] irq_mask;
    } regs_s;

    regs_s r;
    regs_s next_r;
    slave_port_pkg::buffer_state_s flags;
    logic [15:0] status_word;
    logic do_write;
    logic clear_overflow;
    logic clear_underflow;
    logic [slave_port_pkg::irq_width-1:0] irq_pending;

    buffer_flags #(
        .slots(slave_port_pkg::slot_count)
    ) u_flags (
        .clk(clk),
        .reset(reset),
        .enable(r.slave_mode), // see RULE_05
        .master_strobe(master_strobe),
        .local_strobe(local_strobe),
        .clear_overflow(clear_overflow),
        .clear_underflow(clear_underflow),
        .state(flags)
    );

    // unimplemented positions stay zero from the default fill
    always_comb begin
        status_word = 16'h0000; // see RULE_04
        status_word[slave_port_pkg::pos_output_slot_empty +: 4] = flags.output_slot_empty;
        status_word[slave_port_pkg::pos_output_underflow] = flags.output_underflow_sticky;
        status_word[slave_port_pkg::pos_output_all_empty] = &flags.output_slot_empty; // see RULE_08
        status_word[slave_port_pkg::pos_input_slot_full +: 4] = flags.input_slot_full;
        status_word[slave_port_pkg::pos_input_overflow] = flags.input_overflow_sticky;
        status_word[slave_port_pkg::pos_input_all_full] = &flags.input_slot_full; // see RULE_08
    end

    // the sticky flags double as the interrupt status, so one clear serves both views
    assign irq_pending = {flags.input_overflow_sticky, flags.output_underflow_sticky};
    assign irq = |(irq_pending & r.irq_mask);

    assign s_axi_awready = !r.aw_held && !r.bvalid;
    assign s_axi_wready = !r.w_held && !r.bvalid;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rdata = r.rdata;

    assign do_write = r.aw_held && r.w_held;

    // status bits 14 and 6 clear by writing one to them at the status word, or to bits 1 and 0 at the irq status word
    always_comb begin
        clear_overflow = 1'b0;
        clear_underflow = 1'b0;
        if (do_write && r.w_strb[1]
            && (r.aw_addr == slave_port_pkg::addr_status)) begin
            clear_overflow = r.w_data[slave_port_pkg::pos_input_overflow]; // see RULE_06
        end
        if (do_write && r.w_strb[0]
            && (r.aw_addr == slave_port_pkg::addr_status)) begin
            clear_underflow = r.w_data[slave_port_pkg::pos_output_underflow]; // see RULE_03
        end
        if (do_write && r.w_strb[0]
            && (r.aw_addr == slave_port_pkg::addr_irq_status)) begin
            clear_overflow = clear_overflow
                || r.w_data[slave_port_pkg::irq_bit_overflow];
            clear_underflow = clear_underflow
                || r.w_data[slave_port_pkg::irq_bit_underflow];
        end
    end

    always_comb begin
        next_r = r;
        if (s_axi_awvalid && s_axi_awready) begin
            next_r.aw_held = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_r.w_held = 1'b1;
            next_r.w_data = s_axi_wdata;
            next_r.w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_r.aw_held = 1'b0;
            next_r.w_held = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = slave_port_pkg::resp_okay;
            case (r.aw_addr)
                slave_port_pkg::addr_status: begin
                end
                slave_port_pkg::addr_irq_status: begin
                end
                slave_port_pkg::addr_control: begin
                    if (r.w_strb[0]) begin
                        next_r.slave_mode = r.w_data[slave_port_pkg::pos_slave_mode];
                    end
                end
                slave_port_pkg::addr_irq_mask: begin
                    if (r.w_strb[0]) begin
                        next_r.irq_mask = r.w_data[slave_port_pkg::irq_width-1:0];
                    end
                end
                default: begin
                    next_r.bresp = slave_port_pkg::resp_slverr;
                end
            endcase
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = slave_port_pkg::resp_okay;
            next_r.rdata = 32'h00000000;
            case (s_axi_araddr)
                slave_port_pkg::addr_status: begin
                    next_r.rdata[15:0] = status_word;
                end
                slave_port_pkg::addr_control: begin
                    next_r.rdata[slave_port_pkg::pos_slave_mode] = r.slave_mode;
                end
                slave_port_pkg::addr_irq_status: begin
                    next_r.rdata[slave_port_pkg::irq_width-1:0] = irq_pending;
                end
                slave_port_pkg::addr_irq_mask: begin
                    next_r.rdata[slave_port_pkg::irq_width-1:0] = r.irq_mask;
                end
                default: begin
                    next_r.rresp = slave_port_pkg::resp_slverr;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.slave_mode <= slave_port_pkg::reset_slave_mode;
        end else begin
            r <= next_r;
        end
    end
endmodule

// [verification/host_master_model.sv]
// Purpose: external bus master pulsing the slot write and read strobes
// Assumes: one access per go cycle, taken on the clk edge
// Notes: flag checks are left to the bench so it can break them on purpose
`timescale 1ns/1ns
module host_master_model (
    input wire logic clk, // clock
    input wire logic reset, // sync reset
    input wire logic go, // issue one access
    input wire logic wr, // 1 write input slot, 0 read output slot
    input wire logic [1:0] slot, // slot index
    output slave_port_pkg::slot_strobe_s strobe // one-cycle strobes
);
    always_ff @(posedge clk) begin
        strobe <= '0;
        // no flag test here: only a scenario that means to overflow does so
        if (!reset && go) begin
            strobe.write[slot] <= wr;
            strobe.read[slot] <= !wr;
        end
    end
endmodule

// [verification/slave_status_asserts.sv]
// Purpose: bus timing and status field checks on the slave port block
// Assumes: single clock, synchronous reset
// Notes: status fields are judged when a status read returns
`timescale 1ns/1ns
module slave_status_asserts (
    input wire logic clk, // clock
    input wire logic reset, // sync reset
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [3:0] s_axi_araddr, // ar address
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready // r ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [3:0] rd_addr;
    always_ff @(posedge clk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr <= s_axi_araddr;
        end
    end
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    property p_wr_lat; s_wr_both |=> s_wr_answer; endproperty
    property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    property p_zero; s_axi_rvalid |-> s_axi_rdata[5:4] == 2'h0 && s_axi_rdata[13:12] == 2'h0;
    endproperty
    property p_all; s_axi_rvalid && rd_addr == slave_port_pkg::addr_status |->
        s_axi_rdata[7] == &s_axi_rdata[3:0] && s_axi_rdata[15] == &s_axi_rdata[11:8];
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("late write answer");
    a_rd_lat: assert property (p_rd_lat) else $error("late read answer");
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
    a_w_block: assert property (p_w_block) else $error("write taken while busy");
    a_zero: assert property (p_zero) else $error("unused bits set");
    a_all: assert property (p_all) else $error("aggregate flag wrong");
endmodule
bind parallel_slave_buffer_status slave_status_asserts chk (.clk(clk), .reset(reset),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

// [verification/tb.sv]
// Purpose: scenario bench for the slave port buffer status block
// Assumes: status at 0x0, irq status 0x8, mask 0xC, control 0x4
// Notes: every bus wait is bounded by 50 cycles
`timescale 1ns/1ns
module tb;
    logic clk = 0, reset = 1, go = 0, wr = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic awr, wr_rdy, bv, arr, rv, irq;
    logic [1:0] slot = 2'h0, bresp, rresp, wr_exp = 2'h0;
    logic [3:0] awa = 4'h0, ara = 4'h0, ws = 4'hF;
    logic [31:0] wd = 32'h0, rd;
    slave_port_pkg::slot_strobe_s ms, ls = '0;
    int fail_count = 0, cmp_count = 0;
    localparam logic [3:0] st = slave_port_pkg::addr_status;
    always #5 clk = ~clk;
    host_master_model host (.clk(clk), .reset(reset), .go(go), .wr(wr), .slot(slot), .strobe(ms));
    parallel_slave_buffer_status dut (.clk(clk), .reset(reset), .master_strobe(ms),
        .local_strobe(ls), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .irq(irq));
    task automatic end_sim;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 50) begin
            chk("bus answer", 32'h0, 32'h1);
            end_sim();
        end
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        {awa, wd, awv, wv, br} <= {a, d, 3'h7};
        do begin
            tick(n);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_rdy) wv <= 1'b0;
        end while (!bv);
        br <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, wr_exp});
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        int n = 0;
        @(posedge clk);
        {ara, arv, rr} <= {a, 2'h3};
        do begin
            tick(n);
            if (arv && arr) arv <= 1'b0;
        end while (!rv);
        rr <= 1'b0;
        chk("rdata", rd, e);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
    endtask
    task automatic op(input logic host_side, input logic [7:0] v);
        @(posedge clk);
        if (host_side) {go, wr, slot} <= {1'b1, v[2:0]};
        else ls <= v;
        @(posedge clk);
        go <= 1'b0;
        ls <= '0;
    endtask
    task automatic t_input;
        logic [31:0] e = 32'h8F;
        rd_chk(st, e, 2'h0);
        for (int i = 0; i < 4; i++) begin
            op(1'b1, {6'h1, i[1:0]});
            e[8 + i] = 1'b1;
            e[15] = (i == 3);
            rd_chk(st, e, 2'h0);
        end
        bus_wr(slave_port_pkg::addr_irq_mask, 32'h3);
        op(1'b1, 8'h06);
        rd_chk(st, 32'hCF8F, 2'h0);
        chk("irq", {31'h0, irq}, 32'h1);
        op(1'b0, 8'h01);
        rd_chk(st, 32'h4E8F, 2'h0);
        ws <= 4'h1;
        bus_wr(st, 32'h4000);
        rd_chk(st, 32'h4E8F, 2'h0);
        chk("irq", {31'h0, irq}, 32'h1);
        ws <= 4'hF;
        bus_wr(st, 32'h4000);
        chk("irq", {31'h0, irq}, 32'h0);
        op(1'b0, 8'h0E);
        rd_chk(st, 32'h8F, 2'h0);
    endtask
    task automatic t_output;
        op(1'b0, 8'h20);
        rd_chk(st, 32'h0D, 2'h0);
        op(1'b1, 8'h01);
        rd_chk(st, 32'h8F, 2'h0);
        op(1'b1, 8'h01);
        rd_chk(st, 32'hCF, 2'h0);
        rd_chk(slave_port_pkg::addr_irq_status, 32'h1, 2'h0);
        bus_wr(slave_port_pkg::addr_irq_mask, 32'h2);
        chk("irq", {31'h0, irq}, 32'h0);
        rd_chk(slave_port_pkg::addr_irq_mask, 32'h2, 2'h0);
        bus_wr(slave_port_pkg::addr_irq_status, 32'h1);
        rd_chk(st, 32'h8F, 2'h0);
    endtask
    task automatic t_mode;
        bus_wr(slave_port_pkg::addr_control, 32'h0);
        op(1'b1, 8'h07);
        rd_chk(st, 32'h8F, 2'h0);
        bus_wr(slave_port_pkg::addr_control, 32'h1);
        op(1'b1, 8'h07);
        rd_chk(st, 32'h88F, 2'h0);
        rd_chk(4'h2, 32'h0, slave_port_pkg::resp_slverr);
        wr_exp = slave_port_pkg::resp_slverr;
        bus_wr(4'h2, 32'h0);
        wr_exp = slave_port_pkg::resp_okay;
        rd_chk(slave_port_pkg::addr_control, 32'h1, 2'h0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_input();
        t_output();
        t_mode();
        end_sim();
    end
endmodule
